// [core/asr_core.sv]
// Function
// [R1] ready follows conversion flag while select high
// [R2] acquire after reset and each conversion
// [R3] reset input low forces reset state
// [R4] start rising edge enters convert state
// [R5] start ignored during conversion
// [R6] host waits ready or max conversion time
// [R7] blind host cycle is conv max plus acq
// [R8] opcode 1001 reads addressed register
// [R9] opcode 1010 writes data to address
// [R10] other command words are no operation
// [R11] writes on serial clock, readout clock configurable
// [R12] read result in bits 19..12, rest zero; code puts parity in bits 1,0 when parity_enable is set
// [R13] pattern select top bit sends fixed pattern
// [R14] otherwise bits 19..2 carry latest result
// [R15] parity disabled drives bits 1,0 zero
// [R16] parity bits: full span and chosen span
// [R17] select fall: ready low, counter zero, load
// [R18] input register starts frame at zero
// [R19] capture edge counts and shifts, launch shifts
// [R20] select rise: tristate, ready later, decode
// [R21] host waits ready after frame end
// [R22] fewer than 20 clocks is no operation
// [R23] exactly 20 clocks decodes the command
// [R24] long frame keeps last 20 bits
// [R25] short frame output bits stay valid
// [R26] reset state: defaults, ready low, tristate
// [R27] after reset delay enter acquire, ready high
// [R28] register read wins over test pattern
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// frame tag: toggles on every select falling edge
// ****************************************************************
module asr_cs_tag (
	input  wire logic cs_n,	// chip select pin
	input  wire logic nrst,	// raw reset, active low
	output logic      tag	// frame number parity
);
	typedef struct packed {
		logic tog;	// toggles once per frame
	} asr_tag_s;
	asr_tag_s s_q;	// registered state
	asr_tag_s s_d;	// next state

	// next state: flip on each frame start
	always_comb begin
		s_d     = s_q;
		s_d.tog = ~s_q.tog;
	end

	// select pin itself clocks the tag
	always_ff @(negedge cs_n or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tag = s_q.tog;
endmodule : asr_cs_tag

// ****************************************************************
// capture side: counter and input_shift_register on sclk rise
// ****************************************************************
module asr_rx (
	input  wire logic        sclk,	// host serial clock
	input  wire logic        nrst,	// raw reset, active low
	input  wire logic        sdi,	// serial data in
	input  wire logic        frame_tag,	// current frame tag
	output logic [4:0]       clk_cnt,	// clocks seen this frame
	output logic [19:0]      shift_in,	// input_shift_register
	output logic             seen_tag	// tag of last clocked frame
);
	typedef struct packed {
		logic        tag;	// frame tag last seen
		logic [4:0]  cnt;	// saturating clock counter
		logic [19:0] input_shift_register;	// input shift register
	} asr_rx_s;
	asr_rx_s s_q;	// registered state
	asr_rx_s s_d;	// next state
	logic    fresh;	// first capture edge of a frame

	// tag differs only before the first edge of a new frame;
	// the host sets select up ahead of that edge
	always_comb begin
		s_d     = s_q;
		fresh   = (s_q.tag != frame_tag);
		s_d.tag = frame_tag;
		if (fresh) begin
			// zeroed counter and register, then first bit
			s_d.cnt = 5'h01;	// [R17] [R19]
			s_d.input_shift_register = {19'h00000, sdi};	// [R18]
		end else begin
			// only the last 20 bits survive
			s_d.input_shift_register = {s_q.input_shift_register[18:0], sdi};	// [R19] [R24]
			if (s_q.cnt != asr_pkg::CNT_SAT) begin
				s_d.cnt = s_q.cnt + 5'h01;	// [R19]
			end
		end
	end

	// capture edge register
	always_ff @(posedge sclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_cnt  = s_q.cnt;
	assign shift_in = s_q.input_shift_register;
	assign seen_tag = s_q.tag;
endmodule : asr_rx

// ****************************************************************
// launch side: output_shift_register on sclk fall
// ****************************************************************
module asr_tx (
	input  wire logic        sclk,	// host serial clock
	input  wire logic        nrst,	// raw reset, active low
	input  wire logic        frame_tag,	// current frame tag
	input  wire logic [19:0] word,	// frozen output word
	output logic             sdo	// serial data out
);
	typedef struct packed {
		logic        tag;	// frame tag last loaded
		logic [19:0] output_shift_register;	// output shift register
	} asr_tx_s;
	asr_tx_s s_q;	// registered state
	asr_tx_s s_d;	// next state
	logic    fresh;	// frame not yet launched

	// msb goes out at select fall, rest on launch edges
	always_comb begin
		s_d     = s_q;
		fresh   = (s_q.tag != frame_tag);
		s_d.tag = frame_tag;
		if (fresh) begin
			s_d.output_shift_register = {word[18:0], 1'b0};	// [R17] [R19]
		end else begin
			s_d.output_shift_register = {s_q.output_shift_register[18:0], 1'b0};	// [R19]
		end
	end

	// launch edge register
	always_ff @(negedge sclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// loaded word's msb until first launch edge
	assign sdo = fresh ? word[19] : s_q.output_shift_register[19];	// [R17] [R25]
endmodule : asr_tx

// ****************************************************************
// top: state machine, command processor, output word
// ****************************************************************
module asr_core #(
	parameter logic [17:0] PATTERN = asr_pkg::TEST_PATTERN	// fixed pattern
) (
	input  wire logic        ref_clk,	// internal conversion clock
	input  wire logic        nrst,	// reset pin, active low
	input  wire logic        conversion_start,	// start pin
	input  wire logic [17:0] conv_result,	// converter result, two's complement
	input  wire logic        sclk,	// host serial clock
	input  wire logic        cs_n,	// chip select, active low
	input  wire logic        sdi,	// serial data in
	output logic             sdo,	// serial data out
	output logic             sdo_oe_n,	// sdo enable, low drives
	output logic             ready_indicator,	// ready pin
	output logic             output_clock_select	// readout clock choice
);
	// ****************************************************************
	// parity and word building
	// ****************************************************************
	// even parity bit over the given bits
	function automatic logic even_par(input logic [17:0] v);
		even_par = ^v;
	endfunction

	// output word for the next frame
	function automatic logic [19:0] build_word(
		input logic        rd_pend,
		input logic [7:0]  rd_val,
		input logic [7:0]  ctl,
		input logic [17:0] conv
	);
		logic [17:0] body;
		logic [17:0] span;
		logic        parity_enable;
		body   = conv;	// [R14]
		span   = 18'h00000;
		parity_enable = ctl[asr_pkg::PAR_BIT];
		if (rd_pend) begin
			body = {rd_val, 10'h000};	// [R12] [R28]
		end else if (ctl[asr_pkg::PATN_LSB + 2]) begin
			body = PATTERN;	// [R13]
		end
		// partial span: top 4, 8, 12 or all 18 bits
		case (ctl[asr_pkg::SPAN_LSB +: 2])
			2'h0: span = {body[17:14], 14'h0000};
			2'h1: span = {body[17:10], 10'h000};
			2'h2: span = {body[17:6], 6'h00};
			default: span = body;
		endcase
		if (parity_enable) begin
			build_word = {body, even_par(body), even_par(span)};	// [R16]
		end else begin
			build_word = {body, 2'b00};	// [R15]
		end
	endfunction

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic [1:0] rst_sync_q;	// reset release pipe
	logic       rst_n;	// synchronised reset

	// two flops release the reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ****************************************************************
	// link side instances
	// ****************************************************************
	logic        frame_tag;	// select fall tag
	logic [4:0]  clk_cnt;	// counter of last frame
	logic [19:0] shift_in;	// captured command bits
	logic        seen_tag;	// tag the counter belongs to
	logic        sdo_bit;	// launched bit

	asr_cs_tag u_tag (
		.cs_n (cs_n),
		.nrst (nrst),
		.tag  (frame_tag)
	);

	// writes always captured on the host clock
	asr_rx u_rx (
		.sclk      (sclk),	// [R11]
		.nrst      (nrst),
		.sdi       (sdi),
		.frame_tag (frame_tag),
		.clk_cnt   (clk_cnt),
		.shift_in  (shift_in),
		.seen_tag  (seen_tag)
	);

	typedef struct packed {
		logic [1:0]        cs_s;	// select synchroniser
		logic [1:0]        cv_s;	// start synchroniser
		logic [1:0]        tg_s;	// frame tag synchroniser
		logic              cs_prev;	// select, last cycle
		logic              cv_prev;	// start, last cycle
		asr_pkg::asr_state_e state;	// device state
		logic [15:0]       tmr;	// state timer
		logic [17:0]       conv;	// latest conversion result
		logic [19:0]       word;	// output word
		logic              rd_pend;	// read result for next frame
		logic [7:0]        rd_val;	// register value read
		logic [7:0]        ctl;	// output_control_register
		logic [7:0]        proto;	// readout clock register
	} asr_top_s;
	asr_top_s s_q;	// registered state
	asr_top_s s_d;	// next state

	logic       cs_rise;	// frame end seen
	logic       cs_fall;	// frame start seen
	logic       cv_rise;	// start edge seen
	logic       exec;	// command accepted
	logic [3:0] op;	// opcode nibble
	logic [7:0] addr;	// address field
	logic [7:0] wdat;	// data field

	// ****************************************************************
	// state machine and command processor
	// ****************************************************************
	// decode and state updates, one pass per cycle
	always_comb begin
		s_d         = s_q;
		s_d.cs_s    = {s_q.cs_s[0], cs_n};
		s_d.cv_s    = {s_q.cv_s[0], conversion_start};
		s_d.tg_s    = {s_q.tg_s[0], frame_tag};
		s_d.cs_prev = s_q.cs_s[1];
		s_d.cv_prev = s_q.cv_s[1];
		cs_rise     = s_q.cs_s[1] & ~s_q.cs_prev;
		cs_fall     = ~s_q.cs_s[1] & s_q.cs_prev;
		cv_rise     = s_q.cv_s[1] & ~s_q.cv_prev;
		op          = shift_in[19:16];
		addr        = shift_in[15:8];
		wdat        = shift_in[7:0];
		// no clock in this frame or too few: no operation
		exec = cs_rise & (seen_tag == s_q.tg_s[1]) & (clk_cnt >= asr_pkg::FRAME_CNT);	// [R20] [R22] [R23]
		case (s_q.state)
			asr_pkg::ST_RST: begin
				// wait out the exit delay
				if (s_q.tmr == 16'h0000) begin
					s_d.state = asr_pkg::ST_ACQ;	// [R2] [R27]
				end else begin
					s_d.tmr = s_q.tmr - 16'h0001;
				end
			end
			asr_pkg::ST_ACQ: begin
				// start edge launches a conversion
				if (cv_rise) begin
					s_d.state = asr_pkg::ST_CNV;	// [R4]
					s_d.tmr   = 16'(asr_pkg::CONV_CYCLES - 1);
				end
			end
			asr_pkg::ST_CNV: begin
				// start pin not looked at here
				if (s_q.tmr == 16'h0000) begin
					s_d.state = asr_pkg::ST_ACQ;	// [R2]
					s_d.conv  = conv_result;	// [R14]
				end else begin
					s_d.tmr = s_q.tmr - 16'h0001;	// [R5]
				end
			end
			default: begin
				s_d.state = asr_pkg::ST_ACQ;
			end
		endcase
		// read result is consumed by the frame that starts
		if (cs_fall) begin
			s_d.rd_pend = 1'b0;
		end
		// command processor
		if (exec) begin
			if (op == asr_pkg::OP_RD && wdat == 8'h00) begin
				// only mapped addresses make a valid read
				if (addr == asr_pkg::ADDR_OUT_CTL) begin
					s_d.rd_pend = 1'b1;	// [R8]
					s_d.rd_val  = s_q.ctl;
				end else if (addr == asr_pkg::ADDR_PROTO) begin
					s_d.rd_pend = 1'b1;	// [R8]
					s_d.rd_val  = s_q.proto;
				end
			end else if (op == asr_pkg::OP_WR) begin
				if (addr == asr_pkg::ADDR_OUT_CTL) begin
					s_d.ctl = wdat;	// [R9]
				end else if (addr == asr_pkg::ADDR_PROTO) begin
					s_d.proto = wdat;	// [R9]
				end
			end
			// every other pattern changes nothing: [R10]
		end
		// word freezes while a frame runs
		if (s_q.cs_s[1]) begin
			s_d.word = build_word(s_q.rd_pend, s_q.rd_val, s_q.ctl, s_q.conv);
		end
	end

	// state register; reset state loads defaults
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q       <= '0;	// [R3] [R26]
			s_q.cs_s  <= 2'b11;
			s_q.cs_prev <= 1'b1;
			s_q.state <= asr_pkg::ST_RST;
			s_q.tmr   <= 16'(asr_pkg::RST_EXIT_CYCLES - 1);
			s_q.ctl   <= asr_pkg::OUT_CTL_RST;
			s_q.proto <= asr_pkg::PROTO_RST;
		end else begin
			s_q <= s_d;
		end
	end

	asr_tx u_tx (
		.sclk      (sclk),
		.nrst      (nrst),
		.frame_tag (frame_tag),
		.word      (s_q.word),
		.sdo       (sdo_bit)
	);

	// ****************************************************************
	// pins
	// ****************************************************************
	// bus taken only inside a frame and out of reset
	assign sdo      = sdo_bit;
	assign sdo_oe_n = cs_n | (s_q.state == asr_pkg::ST_RST);	// [R17] [R20] [R26]
	// ready: low in frame, follows conversion flag otherwise
	assign ready_indicator = cs_n & s_q.cs_s[1] & ~cs_rise & (s_q.state == asr_pkg::ST_ACQ);	// [R1] [R21]
	assign output_clock_select = s_q.proto[0];	// [R11]

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_ready_frame_low: assert property (!cs_n |-> !ready_indicator)	// [R17]
		else $error("ready high inside a frame");
	a_ready_busy_low: assert property (s_q.state == asr_pkg::ST_CNV |-> !ready_indicator)	// [R1]
		else $error("ready high during conversion");
	a_conv_enter: assert property (s_q.state == asr_pkg::ST_ACQ && cv_rise |=> s_q.state == asr_pkg::ST_CNV)	// [R4]
		else $error("start edge did not convert");
	a_conv_hold: assert property (s_q.state == asr_pkg::ST_CNV && s_q.tmr != 16'h0000
		|=> s_q.state == asr_pkg::ST_CNV && s_q.tmr == $past(s_q.tmr) - 16'h0001)	// [R5]
		else $error("conversion cut short");
	a_conv_bound: assert property (s_q.state == asr_pkg::ST_CNV |-> s_q.tmr < 16'(asr_pkg::CONV_CYCLES))	// [R5]
		else $error("conversion timer out of range");
	a_conv_done: assert property (s_q.state == asr_pkg::ST_CNV && s_q.tmr == 16'h0000
		|=> s_q.state == asr_pkg::ST_ACQ && s_q.conv == $past(conv_result))	// [R2]
		else $error("conversion did not end in acquire");
	a_reset_quiet: assert property (s_q.state == asr_pkg::ST_RST |-> !ready_indicator && sdo_oe_n)	// [R26]
		else $error("reset state drives pins");
	a_reset_exit: assert property (s_q.state == asr_pkg::ST_RST && s_q.tmr == 16'h0000
		|=> s_q.state == asr_pkg::ST_ACQ)	// [R27]
		else $error("reset exit missed");
	a_short_nop: assert property (cs_rise && !exec |=> $stable(s_q.ctl) && $stable(s_q.proto))	// [R22]
		else $error("short frame changed config");
	a_write_ctl: assert property (exec && op == asr_pkg::OP_WR && addr == asr_pkg::ADDR_OUT_CTL
		|=> s_q.ctl == $past(wdat))	// [R9]
		else $error("register write lost");
	a_read_word: assert property (s_q.cs_s[1] && $past(s_q.cs_s[1]) && $past(s_q.rd_pend)
		|-> s_q.word[11:2] == 10'h000 && s_q.word[19:12] == $past(s_q.rd_val))	// [R12]
		else $error("read word malformed");
	a_parity_off: assert property (s_q.cs_s[1] && $past(s_q.cs_s[1]) && !$past(s_q.ctl[asr_pkg::PAR_BIT])
		|-> s_q.word[1:0] == 2'b00)	// [R15]
		else $error("parity bits set while disabled");

	c_conversion: cover property (s_q.state == asr_pkg::ST_CNV ##1 s_q.state == asr_pkg::ST_ACQ);
	c_read_cmd: cover property (exec && op == asr_pkg::OP_RD);
	c_write_cmd: cover property (exec && op == asr_pkg::OP_WR);
	c_short_frame: cover property (cs_rise && !exec);
endmodule : asr_core
`default_nettype wire

// [dv/asr_core_test.sv]
`timescale 1ns/1ps
`default_nettype none
module asr_core_test;
	localparam logic [17:0] PAT = 18'h2c3d1;	// pattern under test
	logic        ref_clk;
	logic        nrst;
	logic        conversion_start;
	logic [17:0] conv_result;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe_n;
	logic        ready_indicator;
	logic        output_clock_select;
	logic [21:0] rx_word;
	logic        rx_stb;
	logic [43:0] exp_q[$];	// {mask, value} per frame
	logic [43:0] exp_e;
	logic [7:0]  ctl;	// model registers
	logic [7:0]  proto;
	logic [7:0]  rd_val;
	logic        rd_pend;
	logic [17:0] conv;
	int          error_cnt = 0;
	int          samples_checked = 0;
	int          seed = 32'h4893;
	int          cyc = 0;

	asr_core #(.PATTERN(PAT)) asr_core_inst (.ref_clk(ref_clk), .nrst(nrst), .conversion_start(conversion_start),
		.conv_result(conv_result), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
		.ready_indicator(ready_indicator), .output_clock_select(output_clock_select));
	asr_host asr_host_inst (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
		.ready_indicator(ready_indicator), .rx_word(rx_word), .rx_stb(rx_stb));

	// ****************************************************************
	// clock, timeout, checking
	// ****************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t pin or count %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [21:0] got, input logic [21:0] exp, input logic [21:0] m);
		samples_checked++;
		if ((got & m) !== (exp & m)) begin
			error_cnt++;
			$display("Error t=%0t frame word %h expected %h", $time, got, exp);
		end
	endtask
	// oldest note against each finished frame
	always @(posedge rx_stb) begin
		exp_e = exp_q.pop_front();
		chk_word(rx_word, exp_e[21:0], exp_e[43:22]);
	end
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ****************************************************************
	// model and drivers
	// ****************************************************************
	function automatic logic [21:0] exp_word();
		logic [17:0] b;
		logic        p0;
		b = rd_pend ? {rd_val, 10'h000} : (ctl[2] ? PAT : conv);
		case (ctl[5:4])
			2'h0: p0 = ^b[17:14];
			2'h1: p0 = ^b[17:10];
			2'h2: p0 = ^b[17:6];
			default: p0 = ^b;
		endcase
		return {2'b00, b, ctl[3] ? {^b, p0} : 2'b00};
	endfunction
	task automatic wait_rdy();
		int k;
		k = 0;
		while (ready_indicator !== 1'b1 && k < 200) begin
			@(negedge ref_clk);
			k++;
		end
		chk_val(ready_indicator, 1'b1);
	endtask
	task automatic run_frame(input logic [31:0] bits, input int n);
		logic [19:0] c;
		logic [21:0] m;
		c = bits[19:0];
		m = {2'b11, 20'hfffff << (n < 20 ? 20 - n : 0)};
		exp_q.push_back({m, exp_word()});
		rd_pend = 1'b0;
		asr_host_inst.frame(bits, n);
		if (n >= 20 && c[19:16] == asr_pkg::OP_WR) begin
			if (c[15:8] == asr_pkg::ADDR_OUT_CTL) ctl = c[7:0];
			if (c[15:8] == asr_pkg::ADDR_PROTO) proto = c[7:0];
		end
		if (n >= 20 && c[19:16] == asr_pkg::OP_RD && c[7:0] == 8'h00) begin
			rd_pend = c[15:8] == asr_pkg::ADDR_OUT_CTL || c[15:8] == asr_pkg::ADDR_PROTO;
			rd_val = c[15:8] == asr_pkg::ADDR_OUT_CTL ? ctl : proto;
		end
		wait_rdy();
		repeat (4) @(posedge ref_clk);
		chk_val(sdo_oe_n, 1'b1);
	endtask
	task automatic convert(input logic extra);
		int k;
		@(posedge ref_clk);
		conv = 18'($random(seed));
		conv_result <= conv;
		conversion_start <= 1'b1;
		repeat (2) @(posedge ref_clk);
		conversion_start <= 1'b0;
		k = 0;
		while (ready_indicator === 1'b1 && k < 8) begin
			@(negedge ref_clk);
			k++;
		end
		chk_val(ready_indicator, 1'b0);
		k = 1;
		while (k < 100) begin
			@(posedge ref_clk);
			conversion_start <= extra && k > 20 && k < 25;
			@(negedge ref_clk);
			if (ready_indicator !== 1'b0) break;
			k++;
		end
		chk_val(k, asr_pkg::CONV_CYCLES);
		conv_result <= 18'($random(seed));
		// acquisition spacing before any next start
		repeat (8) begin
			@(negedge ref_clk);
			chk_val(ready_indicator, 1'b1);
		end
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (10) @(negedge ref_clk);
		chk_val({ready_indicator, sdo_oe_n}, 2'b01);
		@(posedge ref_clk);
		nrst <= 1'b1;
		ctl = 8'h00;
		proto = 8'h00;
		rd_pend = 1'b0;
		conv = 18'h00000;
		wait_rdy();
		chk_val(output_clock_select, 1'b0);
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		nrst = 1'b1;	// dropped at the first edge inside do_reset
		conversion_start = 1'b0;
		conv_result = '0;
		rd_val = 8'h00;
		do_reset();
		convert(1'b1);
		run_frame(32'h0, 20);
		for (int i = 0; i < 4; i++) begin
			run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 2'b00, i[1:0], 4'h8}, 20);
			convert(1'b0);
			run_frame(32'h0, 20);
		end
		run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 8'h04}, 20);
		run_frame({12'h0, asr_pkg::OP_RD, asr_pkg::ADDR_OUT_CTL, 8'h00}, 20);
		run_frame(32'hfffff, 20);
		run_frame({12'h0, asr_pkg::OP_RD, asr_pkg::ADDR_OUT_CTL, 8'h01}, 20);
		run_frame({12'h0, asr_pkg::OP_RD, 8'h7e, 8'h00}, 20);
		run_frame({12'h0, 4'h5, 16'($random(seed))}, 20);
		run_frame({12'h0, 4'hb, 16'($random(seed))}, 20);
		run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 8'h00}, 18);
		run_frame({8'h0, 4'($random(seed)), asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 8'h00}, 24);
		run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_PROTO, 8'h01}, 20);
		chk_val(output_clock_select, 1'b1);
		run_frame({12'h0, asr_pkg::OP_RD, asr_pkg::ADDR_PROTO, 8'h00}, 20);
		for (int i = 0; i < 6; i++) begin
			convert(1'b0);
			run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 8'($random(seed)) & 8'h3f}, 20);
			run_frame({12'h0, asr_pkg::OP_RD, asr_pkg::ADDR_OUT_CTL, 8'h00}, 20);
			run_frame(32'h0, 20);
		end
		run_frame({12'h0, asr_pkg::OP_WR, asr_pkg::ADDR_OUT_CTL, 8'h0c}, 20);
		do_reset();
		convert(1'b0);
		run_frame(32'h0, 20);
		wrap_up();
	end
endmodule // asr_core_test
`default_nettype wire

// [dv/asr_host.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host model: gated serial clock, one frame per call
// ****************************************************************
module asr_host (
	output logic        sclk,	// runs only inside frames
	output logic        cs_n,	// chip select, active low
	output logic        sdi,	// data to device
	input  wire logic   sdo,	// data from device
	input  wire logic   sdo_oe_n,	// device drive enable
	input  wire logic   ready_indicator,	// device ready pin
	output logic [21:0] rx_word,	// {ready, oe_n, first 20 bits}
	output logic        rx_stb	// result strobe
);
	logic lclk;	// free link clock, 12 ns
	logic gate;	// clock gate
	logic sdo_w;	// resolved data line
	assign sdo_w = sdo_oe_n ? 1'bz : sdo;
	assign sclk = gate & lclk;
	// link clock, phase unrelated to ref_clk
	initial begin
		lclk = 1'b0;
		#3.7;
		forever #6 lclk = ~lclk;
	end
	// idle levels
	initial begin
		gate = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
		rx_stb = 1'b0;
		rx_word = '0;
	end
	// send bits[n-1:0] msb first, sample sdo on each of the first 20 rises
	task automatic frame(input logic [31:0] bits, input int n);
		logic [21:0] r;
		r = '0;
		@(negedge lclk);
		cs_n <= 1'b0;
		gate <= 1'b1;
		sdi <= bits[n-1];
		for (int i = 0; i < n; i++) begin
			@(posedge lclk);
			if (i == 0) r[21:20] = {ready_indicator, sdo_oe_n};
			if (i < 20) r[19-i] = sdo_w;
			@(negedge lclk);
			if (i < n - 1) sdi <= bits[n-2-i];
		end
		gate <= 1'b0;
		@(negedge lclk);
		cs_n <= 1'b1;
		sdi <= ~sdi;	// released line shows no stale value
		rx_word <= r;
		rx_stb <= 1'b1;
		@(negedge lclk);
		rx_stb <= 1'b0;
	endtask
endmodule // asr_host
`default_nettype wire

// [shared/asr_pkg.sv]
`default_nettype none
// ****************************************************************
// constants and types for the converter control block
// ****************************************************************
package asr_pkg;
	// device states with binary codes written out
	typedef enum logic [1:0] {
		ST_RST = 2'b00,	// reset state
		ST_ACQ = 2'b01,	// acquire state
		ST_CNV = 2'b10	// convert state
	} asr_state_e;

	// timing: clock period in ps, nominal times in ns
	localparam int CLK_PERIOD_PS   = 8000;	// 125 mhz
	localparam int T_CONV_NS       = 500;	// conversion duration
	localparam int T_RST_EXIT_NS   = 100;	// reset exit delay
	localparam int CONV_CYCLES     = (T_CONV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_EXIT_CYCLES = (T_RST_EXIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// frame geometry
	localparam int          WORD_BITS = 20;	// frame word length
	localparam logic [4:0]  FRAME_CNT = 5'h14;	// 20 clocks: optimal frame
	localparam logic [4:0]  CNT_SAT   = 5'h15;	// counter saturates above 20

	// command opcodes, top nibble
	localparam logic [3:0]  OP_RD = 4'h9;	// register read
	localparam logic [3:0]  OP_WR = 4'ha;	// register write

	// configuration register addresses
	localparam logic [7:0]  ADDR_OUT_CTL = 8'h01;	// output_control_register
	localparam logic [7:0]  ADDR_PROTO   = 8'h02;	// output clock choice

	// output_control_register fields
	localparam int          PATN_LSB = 0;	// test_pattern_select [2:0]
	localparam int          PAR_BIT  = 3;	// parity_enable
	localparam int          SPAN_LSB = 4;	// partial_parity_span [1:0]
	localparam logic [7:0]  OUT_CTL_RST = 8'h00;	// default value
	localparam logic [7:0]  PROTO_RST   = 8'h00;	// default value

	// fixed test pattern in output bits 19..2
	localparam logic [17:0] TEST_PATTERN = 18'h0a5a5;
endpackage : asr_pkg
`default_nettype wire
